// [common/pwr_ctl_pkg.sv]
/*
 Shared constants and types for the converter power and reference control.
 Assumes a single 200 MHz core clock domain.
*/
package pwr_ctl_pkg;
    localparam int CLK_HZ = 200_000_000;
    // Idle timeout, nominal figure in milliseconds
    localparam int IDLE_TIMEOUT_MS = 60;
    // Pairing gap figure in milliseconds; unused, pairing is limited by the idle timeout
    localparam int PAIR_MAX_MS = 70;
    localparam int IDLE_TIMEOUT_CYC = (CLK_HZ / 1000) * IDLE_TIMEOUT_MS;
    localparam int PAIR_MAX_CYC = (CLK_HZ / 1000) * PAIR_MAX_MS;
    localparam int TMR_W = 24;
    localparam logic RESET_STRAP = 1'b0;
    typedef enum logic [1:0] {
        CH_OFF,
        CH_ARMED,
        CH_LIVE
    } ch_state_t;
endpackage

// [core/dac_power_down_control.sv]
/*
 Power-down, wake-up and reference selection for a dual PWM-to-voltage converter.
 Assumes straps and PWM lines are asynchronous pins; analog parts are outside.
*/
// Notes on behaviour
// [RULE1] In sample/hold a channel whose PWM input stays low past the idle timeout powers down.
// [RULE2] The internal reference is off when external reference is chosen or both channels are off.
// [RULE3] A low shutdown input powers down both channels and the internal reference.
// [RULE4] The reference pin is high impedance whenever the internal reference is off.
// [RULE5] In transparent mode operation resumes as soon as shutdown is released.
// [RULE6] In sample/hold all stays off after shutdown until a rising edge on either PWM input.
// [RULE7] A channel code updates when two rising edges are closer than the idle timeout.
// [RULE8] A channel output stays high impedance after wake until its first update.
// [RULE9] A low reference strap selects the internal reference.
// [RULE10] A high reference strap selects the external reference.
// [RULE11] A low idle strap selects transparent mode, a high one sample/hold.
// [RULE12] A channel goes idle after no rising edge for longer than the idle timeout.
// [RULE13] In sample/hold a pair of edges farther apart than the timeout is ignored.
// [RULE14] Each channel has its own idle counter restarted on every rising edge.
module dac_power_down_control
    import pwr_ctl_pkg::*;
#(
    parameter int IDLE_CYC = pwr_ctl_pkg::IDLE_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic shutdown_n,
    input wire logic idle_behaviour_strap,
    input wire logic reference_source_strap,
    input wire logic pwm_a,
    input wire logic pwm_b,
    output logic ref_int_en,
    output logic ref_pin_oe,
    output logic out_a_oe,
    output logic out_b_oe,
    output logic amp_a_en,
    output logic amp_b_en,
    output logic update_a,
    output logic update_b,
    output logic idle_a,
    output logic idle_b,
    output logic idle_high_a,
    output logic idle_high_b,
    output logic sample_hold_mode
);
    import pwr_ctl_pkg::*;

    typedef struct packed {
        logic [2:0] fill;
        logic straps_ok;
        logic sh;
        logic ext_ref;
        logic ref_on;
        logic oe_a;
        logic oe_b;
        logic pw_a;
        logic pw_b;
        logic up_a;
        logic up_b;
        logic id_a;
        logic id_b;
        logic ih_a;
        logic ih_b;
    } top_st_t;

    top_st_t st_r;
    top_st_t st_nxt;
    logic sd_n_s, idl_s, ref_s, pa_s, pb_s;
    logic shutdown_act, wake;
    logic rise_a, rise_b, pwr_a, pwr_b, den_a, den_b;
    logic upd_a, upd_b, idl_a, idl_b, ih_a, ih_b;

    pin_sync3 u_sync_sd (.core_clk(core_clk), .rst_b(rst_b), .pin_in(shutdown_n),
        .pin_out(sd_n_s));
    pin_sync3 u_sync_idl (.core_clk(core_clk), .rst_b(rst_b), .pin_in(idle_behaviour_strap),
        .pin_out(idl_s));
    pin_sync3 u_sync_ref (.core_clk(core_clk), .rst_b(rst_b), .pin_in(reference_source_strap),
        .pin_out(ref_s));
    pin_sync3 u_sync_pa (.core_clk(core_clk), .rst_b(rst_b), .pin_in(pwm_a), .pin_out(pa_s));
    pin_sync3 u_sync_pb (.core_clk(core_clk), .rst_b(rst_b), .pin_in(pwm_b), .pin_out(pb_s));

    // Straps are settled once sync chains have filled; hold shutdown until then
    assign shutdown_act = !sd_n_s || !st_r.straps_ok; // [RULE3]

    // Transparent wakes on release; sample/hold waits for a rising edge
    assign wake = st_r.sh ? (rise_a || rise_b) : 1'b1; // [RULE5] [RULE6]

    pwm_channel #(.IDLE_CYC(IDLE_CYC)) u_ch_a (
        .core_clk(core_clk), .rst_b(rst_b), .pwm_lvl(pa_s), .sample_hold(st_r.sh),
        .shutdown_act(shutdown_act), .wake(wake), .rise(rise_a), .powered(pwr_a),
        .drive_en(den_a), .update(upd_a), .idle(idl_a), .idle_high(ih_a)
    );
    pwm_channel #(.IDLE_CYC(IDLE_CYC)) u_ch_b (
        .core_clk(core_clk), .rst_b(rst_b), .pwm_lvl(pb_s), .sample_hold(st_r.sh),
        .shutdown_act(shutdown_act), .wake(wake), .rise(rise_b), .powered(pwr_b),
        .drive_en(den_b), .update(upd_b), .idle(idl_b), .idle_high(ih_b)
    );

    // Strap capture after reset release, reference control and output flops
    always_comb begin
        st_nxt = st_r;
        // Wait for the pin chains to fill before the straps are trusted
        st_nxt.straps_ok = (st_r.fill == 3'd4);
        if (st_r.fill != 3'd4) begin
            st_nxt.fill = st_r.fill + 3'd1;
        end
        if (!st_r.straps_ok) begin
            st_nxt.sh = idl_s; // [RULE11]
            st_nxt.ext_ref = ref_s; // [RULE9] [RULE10]
        end
        st_nxt.ref_on = !st_r.ext_ref && !shutdown_act && (pwr_a || pwr_b); // [RULE2] [RULE3]
        st_nxt.oe_a = den_a;
        st_nxt.oe_b = den_b;
        st_nxt.pw_a = pwr_a;
        st_nxt.pw_b = pwr_b;
        st_nxt.up_a = upd_a;
        st_nxt.up_b = upd_b;
        st_nxt.id_a = idl_a;
        st_nxt.id_b = idl_b;
        st_nxt.ih_a = ih_a;
        st_nxt.ih_b = ih_b;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ref_int_en = st_r.ref_on;
    assign ref_pin_oe = st_r.ref_on; // [RULE4]
    assign out_a_oe = st_r.oe_a;
    assign out_b_oe = st_r.oe_b;
    assign amp_a_en = st_r.pw_a;
    assign amp_b_en = st_r.pw_b;
    assign update_a = st_r.up_a;
    assign update_b = st_r.up_b;
    assign idle_a = st_r.id_a;
    assign idle_b = st_r.id_b;
    assign idle_high_a = st_r.ih_a;
    assign idle_high_b = st_r.ih_b;
    assign sample_hold_mode = st_r.sh;
endmodule

// [core/pin_sync3.sv]
/*
 Three-stage pin synchroniser; a change counts once stages two and three agree.
 Assumes an asynchronous input and the core clock.
*/
module pin_sync3 (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic pin_in,
    output logic pin_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } sync_st_t;

    sync_st_t st_r;
    sync_st_t st_nxt;

    // Shift chain; output follows when the last two stages agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.q = st_r.s3;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_out = st_r.q;
endmodule

// [core/pwm_channel.sv]
/*
 One output channel: idle timer, pairing of rising edges, power-down and Hi-Z.
 Assumes a synchronised PWM level and idle-behaviour strap from the top.
*/
module pwm_channel
    import pwr_ctl_pkg::*;
#(
    parameter int IDLE_CYC = pwr_ctl_pkg::IDLE_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic pwm_lvl,
    input wire logic sample_hold,
    input wire logic shutdown_act,
    input wire logic wake,
    output logic rise,
    output logic powered,
    output logic drive_en,
    output logic update,
    output logic idle,
    output logic idle_high
);
    typedef struct packed {
        ch_state_t state;
        logic prev;
        logic [TMR_W-1:0] tmr;
        logic timed_out;
        logic upd;
    } ch_st_t;

    localparam logic [TMR_W-1:0] TMR_MAX = TMR_W'(IDLE_CYC);

    ch_st_t st_r;
    ch_st_t st_nxt;
    logic edge_up;

    assign edge_up = pwm_lvl && !st_r.prev;

    // Timer, pairing and per-channel power state
    always_comb begin
        st_nxt = st_r;
        st_nxt.prev = pwm_lvl;
        st_nxt.upd = 1'b0;
        if (edge_up) begin
            st_nxt.tmr = '0; // [RULE14]
            st_nxt.timed_out = 1'b0;
        end else if (st_r.tmr >= TMR_MAX) begin
            st_nxt.timed_out = 1'b1; // [RULE12]
        end else begin
            st_nxt.tmr = st_r.tmr + 1'b1;
        end
        case (st_r.state)
            CH_OFF: begin
                if (wake && !shutdown_act) begin
                    st_nxt.state = CH_ARMED; // [RULE6]
                    // Fresh idle window, pairing still needs two own edges
                    st_nxt.tmr = '0;
                end
            end
            CH_ARMED: begin
                // In sample/hold, woken but left low past the timeout powers down again
                if (sample_hold && !pwm_lvl && st_r.tmr >= TMR_MAX) begin
                    st_nxt.state = CH_OFF; // [RULE1]
                end
                // Second edge within the timeout updates the code
                if (edge_up && !st_r.timed_out) begin
                    st_nxt.state = CH_LIVE; // [RULE7] [RULE8]
                    st_nxt.upd = 1'b1;
                end
            end
            CH_LIVE: begin
                // Edges after a timeout gap are ignored and the code held
                if (edge_up && !st_r.timed_out) begin
                    st_nxt.upd = 1'b1; // [RULE7] [RULE13]
                end
                if (sample_hold && st_r.timed_out && !pwm_lvl) begin
                    st_nxt.state = CH_OFF; // [RULE1]
                end
            end
            default: st_nxt.state = CH_OFF;
        endcase
        if (shutdown_act) begin
            st_nxt.state = CH_OFF; // [RULE3]
            st_nxt.upd = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_r <= '{state: CH_OFF, prev: 1'b0, tmr: '0, timed_out: 1'b1, upd: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise = edge_up;
    assign powered = st_r.state != CH_OFF;
    assign drive_en = st_r.state == CH_LIVE; // [RULE8]
    assign update = st_r.upd;
    assign idle = st_r.timed_out;
    assign idle_high = st_r.timed_out && st_r.prev;
endmodule

// [sim/dac_power_down_control_tb.sv]
/*
 Self-checking bench for the converter power and reference control.
 Assumes a shortened idle timeout of 200 cycles.
*/
module dac_power_down_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IDLE_CYC = 200;
    logic core_clk = 1'b0, rst_b = 1'b0, shutdown_n = 1'b1;
    logic idle_behaviour_strap = 1'b0, reference_source_strap = 1'b0;
    logic run_a = 1'b0, run_b = 1'b0, hi_a = 1'b0, hi_b = 1'b0;
    logic [15:0] per_a = 16'h3c, per_b = 16'h3c;
    logic pwm_a, pwm_b, ref_int_en, ref_pin_oe, out_a_oe, out_b_oe, amp_a_en, amp_b_en;
    logic update_a, update_b, idle_a, idle_b, idle_high_a, idle_high_b, sample_hold_mode;
    int fail_count = 0, num_checks = 0, ua = 0, ub = 0;

    dac_power_down_control #(.IDLE_CYC(IDLE_CYC)) u_dut (.*);
    pwm_source u_src_a (.core_clk(core_clk), .run(run_a), .idle_hi(hi_a), .period(per_a),
        .pwm(pwm_a));
    pwm_source u_src_b (.core_clk(core_clk), .run(run_b), .idle_hi(hi_b), .period(per_b),
        .pwm(pwm_b));

    // Clock and update pulse counters
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (update_a) ua++;
        if (update_b) ub++;
    end

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task boot(input logic ih, input logic rs);
        @(posedge core_clk);
        rst_b <= 1'b0;
        idle_behaviour_strap <= ih;
        reference_source_strap <= rs;
        step(8);
        rst_b <= 1'b1;
        step(30);
    endtask

    task t_transp;
        boot(1'b0, 1'b0);
        chk({amp_a_en, amp_b_en, ref_int_en, ref_pin_oe, out_a_oe, sample_hold_mode}, 8'h3c);
        ua = 0;
        run_a <= 1'b1;
        step(300);
        chk({ua != 0, out_a_oe, out_b_oe}, 8'h06);
        run_a <= 1'b0;
        step(400);
        chk({idle_a, idle_high_a, amp_a_en}, 8'h05);
        shutdown_n <= 1'b0;
        step(20);
        chk({amp_a_en, amp_b_en, ref_int_en, ref_pin_oe}, 8'h00);
        shutdown_n <= 1'b1;
        step(20);
        chk({amp_a_en, ref_int_en}, 8'h03);
        $display("transparent test done");
    endtask

    task t_ext;
        boot(1'b0, 1'b1);
        chk({ref_int_en, ref_pin_oe, amp_a_en}, 8'h01);
        $display("external reference test done");
    endtask

    task t_hold;
        boot(1'b1, 1'b0);
        chk({sample_hold_mode, amp_a_en, amp_b_en, ref_int_en}, 8'h08);
        ub = 0;
        run_b <= 1'b1;
        step(300);
        chk({ub != 0, out_b_oe, amp_b_en, ref_int_en, out_a_oe}, 8'h1e);
        run_b <= 1'b0;
        hi_b <= 1'b1;
        step(400);
        chk({idle_b, idle_high_b, out_b_oe}, 8'h07);
        hi_b <= 1'b0;
        step(400);
        chk({amp_b_en, out_b_oe, amp_a_en, ref_int_en}, 8'h00);
        ub = 0;
        per_b <= 16'h1f4;
        run_b <= 1'b1;
        step(1200);
        chk(ub != 0, 8'h00);
        $display("sample hold test done");
    endtask

    task tally_and_finish;
        $display("checks %0d failures %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        t_transp();
        t_ext();
        t_hold();
        tally_and_finish();
    end
endmodule

// [sim/pdc_checker.sv]
/*
 Port assertions for the converter power and reference control.
 Assumes straps are held steady between resets.
*/
module pdc_checker #(
    parameter int IDLE_CYC = 200
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic shutdown_n,
    input wire logic reference_source_strap,
    input wire logic ref_int_en,
    input wire logic ref_pin_oe,
    input wire logic out_a_oe,
    input wire logic out_b_oe,
    input wire logic amp_a_en,
    input wire logic amp_b_en,
    input wire logic update_a,
    input wire logic update_b,
    input wire logic idle_a,
    input wire logic idle_high_a,
    input wire logic sample_hold_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Reference and shutdown relations
    a_ref_pin_follow: assert property (ref_pin_oe == ref_int_en)
        else $error("ref pin drive differs from ref enable");
    a_ext_ref_off: assert property (reference_source_strap |-> !ref_int_en)
        else $error("internal ref on with external ref chosen");
    a_both_off_ref: assert property ((!amp_a_en && !amp_b_en)[*3] |-> !ref_int_en)
        else $error("internal ref on with both channels off");
    a_shutdown_all: assert property (
        (!shutdown_n)[*8] |-> !(amp_a_en || amp_b_en || ref_int_en))
        else $error("power still on during shutdown");
    a_transp_wake: assert property (
        (shutdown_n && !sample_hold_mode && !reference_source_strap)[*8]
        |-> ##2 (ref_int_en && amp_a_en))
        else $error("transparent mode did not resume");
    // Channel output relations
    a_oe_powered: assert property (out_a_oe |-> amp_a_en)
        else $error("output driven while channel off");
    a_update_drives: assert property (update_a |-> out_a_oe)
        else $error("update while output high impedance");
    a_oe_rise_upd: assert property ($rose(out_b_oe) |-> update_b)
        else $error("output driven without update");
    a_idle_no_upd: assert property (idle_a |-> !update_a)
        else $error("update after idle gap");
    a_sh_idle_off: assert property (
        $rose(idle_a) && sample_hold_mode && !idle_high_a |-> ##[0:2] !amp_a_en)
        else $error("idle low channel not powered down");
endmodule

bind dac_power_down_control pdc_checker #(.IDLE_CYC(IDLE_CYC)) u_chk (.*);

// [sim/pwm_source.sv]
/*
 Controller model producing one PWM line.
 Assumes the bench sets period and idle level between bursts.
*/
module pwm_source (
    input wire logic core_clk,
    input wire logic run,
    input wire logic idle_hi,
    input wire logic [15:0] period,
    output logic pwm
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_r;
    initial pwm = 1'b0;
    // Square wave while running, steady idle level otherwise
    always @(posedge core_clk) begin
        if (!run || cnt_r >= period - 16'h1) begin
            cnt_r <= 16'h0;
        end else begin
            cnt_r <= cnt_r + 16'h1;
        end
        pwm <= run ? (cnt_r < (period >> 1)) : idle_hi;
    end
endmodule
